// ---- rtl/stc_cfg.svh ----
// stc_cfg.svh: register offsets, field positions, reset values and timing figures
// assumes: included by the package and by the design file, by its bare name
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

`define STC_ADDR_W       8
`define STC_OFF_CLK_LOW  8'h00
`define STC_OFF_CLK_HIGH 8'h04
`define STC_OFF_CMP_LOW  8'h08
`define STC_OFF_CMP_HIGH 8'h0C
`define STC_OFF_MSK_LOW  8'h10
`define STC_OFF_MSK_HIGH 8'h14
`define STC_OFF_CTRL     8'h18
`define STC_OFF_STATUS   8'h1C
`define STC_OFF_IMASK    8'h20

// field positions in the clock reference high word
`define STC_EXT_LSB      1
`define STC_EXT_W        9
`define STC_BASE_W       33
// control word
`define STC_CTRL_EN_BIT  0
`define STC_CTRL_MODE_LSB 1
`define STC_CTRL_W       3
`define STC_CTRL_MODE_W  2
// single-bit high halves of the compare and mask values
`define STC_TOP_BIT      0
// status word
`define STC_ST_MATCH_BIT 0
`define STC_ST_W         1

`define STC_EXT_WRAP     9'h12B
`define STC_RST_WORD     32'h0000_0000
`define STC_RST_EXT      9'h000
`define STC_RST_BASE     33'h0_0000_0000
`define STC_RST_CTRL     3'h0
`define STC_RST_ST       1'h0
`define STC_EXT_HZ       27000000
`define STC_CLK_HZ       20000000

`endif

// ---- rtl/stc_pkg.sv ----
// stc_pkg.sv: types shared by the compare block
// assumes: stc_cfg.svh on the include path
`include "stc_cfg.svh"
package stc_pkg;
    // capture mode field of the control register
    typedef enum logic [1:0] {
        STC_MODE_VIDEO = 2'h0,
        STC_MODE_RAW   = 2'h1,
        STC_MODE_TS    = 2'h2
    } stc_mode_t;
endpackage

// ---- rtl/stc_time_compare.sv ----
// stc_time_compare.sv: system time clock counter, readout and absolute-time compare
// assumes: single core clock, plain strobe register port, ext_tick from a 27 MHz domain
//          already synchronised into core_clk as a one-cycle pulse
`timescale 1ns/1ns
`include "stc_cfg.svh"

module stc_time_compare
    import stc_pkg::*;
#(
    parameter int ADDR_W = `STC_ADDR_W
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    // 27 MHz system clock tick, one core cycle per tick
    input  wire logic              ext_tick,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // interrupt
    output logic                   irq
);

    if (ADDR_W < `STC_ADDR_W) begin : g_addr_w_check
        $error("address width too small for the register map");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [`STC_EXT_W-1:0]  ext_q;
    logic [`STC_BASE_W-1:0] base_q;
    logic [31:0]            cmp_low_q;
    logic                   cmp_high_q;
    logic [31:0]            msk_low_q;
    logic                   msk_high_q;
    logic [`STC_CTRL_W-1:0] ctrl_q;
    logic [`STC_ST_W-1:0]   status_q;
    logic [`STC_ST_W-1:0]   imask_q;
    logic [31:0]            rdata_q;
    logic                   irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire [ADDR_W-1:0] a = reg_addr;
    wire hit_cmp_low  = reg_wr && (a == ADDR_W'(`STC_OFF_CMP_LOW));
    wire hit_cmp_high = reg_wr && (a == ADDR_W'(`STC_OFF_CMP_HIGH));
    wire hit_msk_low  = reg_wr && (a == ADDR_W'(`STC_OFF_MSK_LOW));
    wire hit_msk_high = reg_wr && (a == ADDR_W'(`STC_OFF_MSK_HIGH));
    wire hit_ctrl     = reg_wr && (a == ADDR_W'(`STC_OFF_CTRL));
    wire hit_status   = reg_wr && (a == ADDR_W'(`STC_OFF_STATUS));
    wire hit_imask    = reg_wr && (a == ADDR_W'(`STC_OFF_IMASK));

    wire stc_mode_t mode = stc_mode_t'(ctrl_q[`STC_CTRL_MODE_LSB +: `STC_CTRL_MODE_W]);
    wire ts_mode    = (mode == STC_MODE_TS);
    wire cmp_enable = ctrl_q[`STC_CTRL_EN_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // counter
    // extension wraps at 300 ticks
    wire ext_wrap = (ext_q == `STC_EXT_WRAP);
    wire [`STC_EXT_W-1:0] ext_d =
        !(ts_mode && ext_tick) ? ext_q :
        ext_wrap ? `STC_RST_EXT : ext_q + `STC_EXT_W'(1);
    // base advances once per 300 ticks: 90 kHz nominal
    wire [`STC_BASE_W-1:0] base_d =
        (ts_mode && ext_tick && ext_wrap) ? base_q + `STC_BASE_W'(1) : base_q;

    ////////////////////////////////////////////////////////////////////////////
    // compare
    // full 33-bit compare and mask values
    wire [`STC_BASE_W-1:0] cmp_full = {cmp_high_q, cmp_low_q};
    wire [`STC_BASE_W-1:0] msk_full = {msk_high_q, msk_low_q};
    wire [`STC_BASE_W-1:0] bit_agree;
    for (genvar i = 0; i < `STC_BASE_W; i++) begin : g_bit_cmp
        // a mask bit of one forces its bit to agree
        assign bit_agree[i] = msk_full[i] || (cmp_full[i] == base_q[i]);
    end
    wire cmp_equal = &bit_agree;
    // match only when enabled in transport stream mode
    wire match_ev  = ts_mode && cmp_enable && cmp_equal;
    // set beats write-one-to-clear
    wire [`STC_ST_W-1:0] status_d =
        (status_q & ~(hit_status ? reg_wdata[`STC_ST_W-1:0] : '0)) | `STC_ST_W'(match_ev);
    wire irq_d = |(status_d & imask_q);

    ////////////////////////////////////////////////////////////////////////////
    // readback
    wire [31:0] clk_high_word;
    // upper bits zero; fields only in stream mode
    assign clk_high_word = ts_mode ?
        {22'h00_0000, ext_q, base_q[`STC_BASE_W-1]} : `STC_RST_WORD;
    wire [31:0] rd_mux =
        (a == ADDR_W'(`STC_OFF_CLK_LOW))  ? (ts_mode ? base_q[31:0] : `STC_RST_WORD) :
        (a == ADDR_W'(`STC_OFF_CLK_HIGH)) ? clk_high_word :
        (a == ADDR_W'(`STC_OFF_CMP_LOW))  ? cmp_low_q :
        (a == ADDR_W'(`STC_OFF_CMP_HIGH)) ? {31'h0000_0000, cmp_high_q} :
        (a == ADDR_W'(`STC_OFF_MSK_LOW))  ? msk_low_q :
        (a == ADDR_W'(`STC_OFF_MSK_HIGH)) ? {31'h0000_0000, msk_high_q} :
        (a == ADDR_W'(`STC_OFF_CTRL))     ? {29'h0000_0000, ctrl_q} :
        (a == ADDR_W'(`STC_OFF_STATUS))   ? {31'h0000_0000, status_q} :
        (a == ADDR_W'(`STC_OFF_IMASK))    ? {31'h0000_0000, imask_q} :
        `STC_RST_WORD;

    ////////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_q    <= `STC_RST_EXT;
            base_q   <= `STC_RST_BASE;
            status_q <= `STC_RST_ST;
            irq_q    <= 1'b0;
            rdata_q  <= `STC_RST_WORD;
        end else begin
            ext_q    <= ext_d;
            base_q   <= base_d;
            status_q <= status_d;
            irq_q    <= irq_d;
            rdata_q  <= reg_rd ? rd_mux : `STC_RST_WORD;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_low_q  <= `STC_RST_WORD;
            cmp_high_q <= 1'b0;
            msk_low_q  <= `STC_RST_WORD;
            msk_high_q <= 1'b0;
            ctrl_q     <= `STC_RST_CTRL;
            imask_q    <= `STC_RST_ST;
        end else begin
            // low compare word, all 32 bits writable
            if (hit_cmp_low) begin
                cmp_low_q <= reg_wdata;
            end
            if (hit_cmp_high) begin
                cmp_high_q <= reg_wdata[`STC_TOP_BIT];
            end
            if (hit_msk_low) begin
                msk_low_q <= reg_wdata;
            end
            if (hit_msk_high) begin
                msk_high_q <= reg_wdata[`STC_TOP_BIT];
            end
            if (hit_ctrl) begin
                ctrl_q <= reg_wdata[`STC_CTRL_W-1:0];
            end
            if (hit_imask) begin
                imask_q <= reg_wdata[`STC_ST_W-1:0];
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // upper bits zero
    a_high_upper_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && a == ADDR_W'(`STC_OFF_CLK_HIGH) |=> reg_rdata[31:10] == 22'h00_0000)
        else $error("upper bits of clock high word not zero");

    a_ext_readback: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && a == ADDR_W'(`STC_OFF_CLK_HIGH) && ts_mode
        |=> reg_rdata[9:1] == $past(ext_q))
        else $error("extension field readback wrong");

    a_top_bit_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && a == ADDR_W'(`STC_OFF_CLK_HIGH) && ts_mode
        |=> reg_rdata[0] == $past(base_q[`STC_BASE_W-1]))
        else $error("base top bit readback wrong");

    a_cmp_low_store: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hit_cmp_low ##1 (reg_rd && a == ADDR_W'(`STC_OFF_CMP_LOW) && !hit_cmp_low)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("low compare word not kept");

    a_match_sets: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        match_ev |=> status_q[`STC_ST_MATCH_BIT] && irq == $past(imask_q[`STC_ST_MATCH_BIT]))
        else $error("match did not set status");

    a_set_wins: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hit_status && reg_wdata[`STC_ST_MATCH_BIT] && match_ev
        |=> status_q[`STC_ST_MATCH_BIT])
        else $error("clear won over a live match");

    a_w1c_clears: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        hit_status && reg_wdata[`STC_ST_MATCH_BIT] && !match_ev
        |=> !status_q[`STC_ST_MATCH_BIT])
        else $error("status bit not cleared by write of one");

    a_irq_needs_status: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !status_q[`STC_ST_MATCH_BIT] |-> !irq)
        else $error("interrupt high with status clear");

    a_irq_raised: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        status_q[`STC_ST_MATCH_BIT] && imask_q[`STC_ST_MATCH_BIT] && !hit_status |=> irq)
        else $error("interrupt low with unmasked status set");

    a_idle_modes: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ts_mode |=> $stable(base_q) && $stable(ext_q))
        else $error("counter moved outside stream mode");

    a_idle_no_match: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ts_mode && !status_q[`STC_ST_MATCH_BIT] |=> !status_q[`STC_ST_MATCH_BIT])
        else $error("match raised outside stream mode");

    a_idle_read_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && !ts_mode
        && (a == ADDR_W'(`STC_OFF_CLK_LOW) || a == ADDR_W'(`STC_OFF_CLK_HIGH))
        |=> reg_rdata == `STC_RST_WORD)
        else $error("clock word not zero outside stream mode");

    a_base_step: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ts_mode && ext_tick && ext_wrap |=> base_q == $past(base_q) + 33'h1)
        else $error("base did not advance on wrap");

    a_low_word_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && ts_mode && a == ADDR_W'(`STC_OFF_CLK_LOW)
        |=> reg_rdata == $past(base_q[31:0]))
        else $error("clock low word readback wrong");

    a_ext_step: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ts_mode && ext_tick && !ext_wrap |=> ext_q == $past(ext_q) + 9'h1 && $stable(base_q))
        else $error("extension did not advance");

    a_ext_wraps: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ts_mode && ext_tick && ext_q == `STC_EXT_WRAP |=> ext_q == `STC_RST_EXT)
        else $error("extension did not wrap to zero");

    a_ext_bound: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ext_q <= `STC_EXT_WRAP)
        else $error("extension beyond its wrap value");

    a_no_tick_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !ext_tick |=> $stable(ext_q) && $stable(base_q))
        else $error("counter moved without a tick");

    a_cmp_high_read: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        reg_rd && a == ADDR_W'(`STC_OFF_CMP_HIGH)
        |=> reg_rdata == {31'h0000_0000, $past(cmp_high_q)})
        else $error("top compare bit readback wrong");

    a_mask_excl: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ts_mode && cmp_enable && (((cmp_full ^ base_q) & ~msk_full) != '0)
        && !hit_status && !status_q[0] |=> !status_q[0])
        else $error("unmasked mismatch raised match");

    a_mask_hides: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ts_mode && cmp_enable && (&((cmp_full ~^ base_q) | msk_full))
        |=> status_q[`STC_ST_MATCH_BIT])
        else $error("masked equality did not set match");

    // read data stand one cycle only
    a_rdata_idle: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == `STC_RST_WORD)
        else $error("read data outside the read answer cycle");

endmodule // stc_time_compare

// ---- test/stc_time_compare_bench.sv ----
// stc_time_compare_bench.sv: self-checking bench for the system time compare block
// assumes: single 20 MHz core clock, plain strobe register port, bench drives all ports
`timescale 1ns/1ns
`include "stc_cfg.svh"

module stc_time_compare_bench import stc_pkg::*; ;

    logic        core_clk  = 1'b0;
    logic        rst_n     = 1'b0;
    logic        ext_tick  = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic        irq;
    int          err_count       = 0;
    int          samples_checked = 0;
    logic [31:0] d;
    logic [31:0] cl;
    logic [8:0]  n;
    logic [7:0]  offs [7] = '{`STC_OFF_CMP_LOW, `STC_OFF_CMP_HIGH, `STC_OFF_MSK_LOW,
                              `STC_OFF_MSK_HIGH, `STC_OFF_CTRL, `STC_OFF_STATUS, `STC_OFF_IMASK};
    logic [1:0]  idle_modes [3] = '{2'h0, 2'h1, 2'h3};

    stc_time_compare stc_time_compare_inst (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .ext_tick  (ext_tick),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_rdata (reg_rdata),
        .irq       (irq)
    );

    always #25 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] clk_high(input logic [8:0] ext, input logic top);
        return {22'h00_0000, ext, top};
    endfunction

    function automatic logic [31:0] ctrl_word(input logic en, input logic [1:0] mode);
        return {29'h0000_0000, mode, en};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // write strobe is held across back-to-back writes, released by the other tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_wr   <= 1'b0;
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
        @(posedge core_clk);
    endtask

    task automatic ticks(input int k);
        reg_wr   <= 1'b0;
        ext_tick <= 1'b1;
        repeat (k) @(posedge core_clk);
        ext_tick <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic idle_chk_irq(input logic exp);
        reg_wr <= 1'b0;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check({31'h0000_0000, irq}, {31'h0000_0000, exp});
        @(posedge core_clk);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        d = $urandom(79138);
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        foreach (offs[i]) begin
            rd(offs[i], d);
            check(d, 32'h0000_0000);
        end
        for (int i = 0; i < 4; i++) begin
            cl = $urandom;
            wr(`STC_OFF_CMP_LOW, $urandom);
            wr(`STC_OFF_CMP_LOW, cl);
            rd(`STC_OFF_CMP_LOW, d);
            check(d, cl);
        end
        wr(`STC_OFF_CMP_HIGH, 32'hFFFF_FFFF);
        rd(`STC_OFF_CMP_HIGH, d);
        check(d, 32'h0000_0001);
        wr(`STC_OFF_CTRL, ctrl_word(1'b0, STC_MODE_TS));
        ticks(300);
        n = 9'(1 + $urandom % 298);
        ticks(int'(n));
        rd(`STC_OFF_CLK_HIGH, d);
        check(d, clk_high(n, 1'b0));
        rd(`STC_OFF_CLK_LOW, d);
        check(d, 32'h0000_0001);
        wr(`STC_OFF_CLK_HIGH, 32'hFFFF_FFFF);
        wr(`STC_OFF_CLK_LOW, 32'hFFFF_FFFF);
        rd(`STC_OFF_CLK_HIGH, d);
        check(d, clk_high(n, 1'b0));
        rd(8'h40, d);
        check(d, 32'h0000_0000);
        // low byte equals the frozen base, bit 8 differs so only the mask hides it
        cl = ($urandom & 32'hFFFF_FF00) | 32'h0000_0101;
        wr(`STC_OFF_CMP_LOW, cl);
        wr(`STC_OFF_MSK_LOW, 32'hFFFF_FF00);
        wr(`STC_OFF_MSK_HIGH, 32'h0000_0001);
        foreach (idle_modes[i]) begin
            wr(`STC_OFF_CTRL, ctrl_word(1'b1, idle_modes[i]));
            ticks(7);
            rd(`STC_OFF_CLK_HIGH, d);
            check(d, 32'h0000_0000);
            rd(`STC_OFF_STATUS, d);
            check(d, 32'h0000_0000);
        end
        wr(`STC_OFF_CTRL, ctrl_word(1'b0, STC_MODE_TS));
        rd(`STC_OFF_CLK_HIGH, d);
        check(d, clk_high(n, 1'b0));
        rd(`STC_OFF_STATUS, d);
        check(d, 32'h0000_0000);
        wr(`STC_OFF_CTRL, ctrl_word(1'b1, STC_MODE_TS));
        idle_chk_irq(1'b0);
        rd(`STC_OFF_STATUS, d);
        check(d, 32'h0000_0001);
        wr(`STC_OFF_IMASK, 32'h0000_0001);
        idle_chk_irq(1'b1);
        // a clear that meets a live match loses to it
        wr(`STC_OFF_STATUS, 32'h0000_0001);
        rd(`STC_OFF_STATUS, d);
        check(d, 32'h0000_0001);
        // compare disabled before the compare fields are touched
        wr(`STC_OFF_CTRL, ctrl_word(1'b0, STC_MODE_TS));
        wr(`STC_OFF_STATUS, 32'h0000_0001);
        idle_chk_irq(1'b0);
        rd(`STC_OFF_STATUS, d);
        check(d, 32'h0000_0000);
        wr(`STC_OFF_MSK_LOW, 32'h0000_0000);
        wr(`STC_OFF_CTRL, ctrl_word(1'b1, STC_MODE_TS));
        idle_chk_irq(1'b0);
        rd(`STC_OFF_STATUS, d);
        check(d, 32'h0000_0000);
        end_sim();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #(50 * 4000);
        err_count++;
        end_sim();
    end

endmodule // stc_time_compare_bench
